/* rhm_pkg.sv */
// package for the right headphone mix register bank
package rhm_pkg;

    // ----------------------------------------------------------------
    // register indices on page zero
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_RSVD_A    = 8'h3E; // reserved location
    localparam logic [7:0] IDX_RGS_RHP   = 8'h3F; // right gain stage
    localparam logic [7:0] IDX_RDAC_RHP  = 8'h40; // right dac path
    localparam logic [7:0] IDX_RHP_CTRL  = 8'h41; // driver control
    localparam logic [7:0] IDX_RSVD_B    = 8'h42; // reserved location
    localparam logic [7:0] IDX_LGS_RCOM  = 8'h43; // left gain to common
    localparam logic [7:0] IDX_LDAC_RCOM = 8'h44; // left dac to common
    localparam logic [7:0] IDX_RSVD_C    = 8'h45; // reserved location
    localparam logic [7:0] IDX_RGS_RCOM  = 8'h46; // right gain to common
    localparam logic [7:0] PAGE_ZERO     = 8'h00; // only page served

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int ROUTE_BIT = 7; // routing enable
    localparam int VOL_HI    = 6; // volume msb
    localparam int LVL_HI    = 7; // level field msb
    localparam int LVL_LO    = 4; // level field lsb
    localparam int MUTE_BIT  = 3; // 1 = unmuted
    localparam int PDHZ_BIT  = 2; // 1 = hi-z when down
    localparam int PEND_BIT  = 1; // read-only gain pending
    localparam int PWR_BIT   = 0; // full power up
    localparam logic [7:0] RST_ZERO = 8'h00;       // mix and reserved
    localparam logic [7:0] RST_CTRL = 8'h06;       // hi-z, pending set
    localparam logic [7:0] CTRL_RW_MASK = 8'hFD;   // pending not writable
    localparam logic [3:0] LVL_MAX = 4'h9;         // 9 dB top code

    // one mix path: enable plus volume
    typedef struct packed {
        logic       route;
        logic [6:0] vol;
    } rhm_mix_s;

    // driver control outputs
    typedef struct packed {
        logic [3:0] level;
        logic       unmute;
        logic       pd_hiz;
        logic       power;
    } rhm_drv_s;

    // register write request
    typedef struct packed {
        logic       wr;
        logic [7:0] page;
        logic [7:0] idx;
        logic [7:0] data;
    } rhm_wr_s;

endpackage

/* rhm_regs.sv */
// right headphone mix register bank with gain-applied status
`timescale 1ns/1ps

// Behaviour
// [RQ1] index 63: right gain stage route, volume
// [RQ2] index 64: right dac route, volume
// [RQ3] index 67: left gain stage to common
// [RQ4] index 68: left dac to common
// [RQ5] index 70: right gain stage to common
// [RQ6] control bits 7..4 set level, reset zero
// [RQ7] software never writes level codes 10..15
// [RQ8] control bit 3 unmutes, resets muted
// [RQ9] control bit 2 hi-z power down, reset one
// [RQ10] control bit 1 read-only gain pending flag
// [RQ11] control bit 0 powers driver, reset zero
// [RQ12] reserved 62, 66, 69 plain zero-reset storage
// [RQ13] eight-bit registers, page zero, reset contents
module rhm_regs (
    input  wire logic              mclk,       // 100 MHz clock
    input  wire logic              nrst,       // async reset, low
    input  wire rhm_pkg::rhm_wr_s  wr_req,     // write request
    input  wire logic [7:0]        rd_page,    // read page select
    input  wire logic [7:0]        rd_idx,     // read index
    output logic [7:0]             rd_data,    // read data, registered
    input  wire logic              gain_done,  // analog ramp applied
    output rhm_pkg::rhm_mix_s      mix_rgs_rhp,   // right gain -> hp
    output rhm_pkg::rhm_mix_s      mix_rdac_rhp,  // right dac -> hp
    output rhm_pkg::rhm_mix_s      mix_lgs_rcom,  // left gain -> com
    output rhm_pkg::rhm_mix_s      mix_ldac_rcom, // left dac -> com
    output rhm_pkg::rhm_mix_s      mix_rgs_rcom,  // right gain -> com
    output rhm_pkg::rhm_drv_s      drv             // driver controls
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] rgs_rhp_q;   // index 63
    logic [7:0] rdac_rhp_q;  // index 64
    logic [7:0] ctrl_q;      // index 65, writable bits only
    logic [7:0] lgs_rcom_q;  // index 67
    logic [7:0] ldac_rcom_q; // index 68
    logic [7:0] rgs_rcom_q;  // index 70
    logic [7:0] rsvd_a_q;    // index 62
    logic [7:0] rsvd_b_q;    // index 66
    logic [7:0] rsvd_c_q;    // index 69
    logic       pend_q;      // gains not yet applied
    logic       hit_page;    // read access targets page zero

    // write strobe for one index on page zero
    function automatic logic wr_hit(input rhm_pkg::rhm_wr_s r,
                                    input logic [7:0] idx);
        wr_hit = r.wr && (r.page == rhm_pkg::PAGE_ZERO) && (r.idx == idx);
    endfunction

    // ----------------------------------------------------------------
    // mix path registers
    // ----------------------------------------------------------------
    // plain eight-bit storage, all clear from reset
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rgs_rhp_q   <= rhm_pkg::RST_ZERO; // [RQ13]
            rdac_rhp_q  <= rhm_pkg::RST_ZERO;
            lgs_rcom_q  <= rhm_pkg::RST_ZERO;
            ldac_rcom_q <= rhm_pkg::RST_ZERO;
            rgs_rcom_q  <= rhm_pkg::RST_ZERO;
        end
        else
        begin
            if (wr_hit(wr_req, rhm_pkg::IDX_RGS_RHP))
                rgs_rhp_q <= wr_req.data;   // [RQ1]
            if (wr_hit(wr_req, rhm_pkg::IDX_RDAC_RHP))
                rdac_rhp_q <= wr_req.data;  // [RQ2]
            if (wr_hit(wr_req, rhm_pkg::IDX_LGS_RCOM))
                lgs_rcom_q <= wr_req.data;  // [RQ3]
            if (wr_hit(wr_req, rhm_pkg::IDX_LDAC_RCOM))
                ldac_rcom_q <= wr_req.data; // [RQ4]
            if (wr_hit(wr_req, rhm_pkg::IDX_RGS_RCOM))
                rgs_rcom_q <= wr_req.data;  // [RQ5]
        end
    end

    // ----------------------------------------------------------------
    // reserved locations
    // ----------------------------------------------------------------
    // kept as real storage so read-back matches what was written
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsvd_a_q <= rhm_pkg::RST_ZERO; // [RQ12]
            rsvd_b_q <= rhm_pkg::RST_ZERO;
            rsvd_c_q <= rhm_pkg::RST_ZERO;
        end
        else
        begin
            if (wr_hit(wr_req, rhm_pkg::IDX_RSVD_A))
                rsvd_a_q <= wr_req.data; // [RQ12]
            if (wr_hit(wr_req, rhm_pkg::IDX_RSVD_B))
                rsvd_b_q <= wr_req.data;
            if (wr_hit(wr_req, rhm_pkg::IDX_RSVD_C))
                rsvd_c_q <= wr_req.data;
        end
    end

    // ----------------------------------------------------------------
    // driver control
    // ----------------------------------------------------------------
    // level codes above nine are stored as written; software keeps
    // out of them, the analog side treats them as undefined
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            ctrl_q <= rhm_pkg::RST_CTRL & rhm_pkg::CTRL_RW_MASK;
        else if (wr_hit(wr_req, rhm_pkg::IDX_RHP_CTRL))
            ctrl_q <= wr_req.data & rhm_pkg::CTRL_RW_MASK; // [RQ6] [RQ7]
    end

    // ----------------------------------------------------------------
    // gain pending status
    // ----------------------------------------------------------------
    // any write to a gain feeding these outputs re-arms pending;
    // a new write wins over a completion in the same cycle
    logic gain_wr; // a volume-bearing mix register or the level-bearing control register is written
    assign gain_wr = wr_hit(wr_req, rhm_pkg::IDX_RGS_RHP)
                   | wr_hit(wr_req, rhm_pkg::IDX_RDAC_RHP)
                   | wr_hit(wr_req, rhm_pkg::IDX_RHP_CTRL)
                   | wr_hit(wr_req, rhm_pkg::IDX_LGS_RCOM)
                   | wr_hit(wr_req, rhm_pkg::IDX_LDAC_RCOM)
                   | wr_hit(wr_req, rhm_pkg::IDX_RGS_RCOM);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pend_q <= rhm_pkg::RST_CTRL[rhm_pkg::PEND_BIT]; // [RQ10]
        else if (gain_wr)
            pend_q <= 1'b1;  // [RQ10]
        else if (gain_done)
            pend_q <= 1'b0;  // [RQ10]
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    assign hit_page = (rd_page == rhm_pkg::PAGE_ZERO); // [RQ13]

    // registered read, other indices return zero
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rd_data <= rhm_pkg::RST_ZERO;
        else if (!hit_page)
            rd_data <= rhm_pkg::RST_ZERO;
        else
        begin
            unique case (rd_idx)
                rhm_pkg::IDX_RSVD_A:    rd_data <= rsvd_a_q;
                rhm_pkg::IDX_RGS_RHP:   rd_data <= rgs_rhp_q;
                rhm_pkg::IDX_RDAC_RHP:  rd_data <= rdac_rhp_q;
                rhm_pkg::IDX_RHP_CTRL:
                    rd_data <= ctrl_q
                             | {6'h00, pend_q, 1'b0}; // [RQ10]
                rhm_pkg::IDX_RSVD_B:    rd_data <= rsvd_b_q;
                rhm_pkg::IDX_LGS_RCOM:  rd_data <= lgs_rcom_q;
                rhm_pkg::IDX_LDAC_RCOM: rd_data <= ldac_rcom_q;
                rhm_pkg::IDX_RSVD_C:    rd_data <= rsvd_c_q;
                rhm_pkg::IDX_RGS_RCOM:  rd_data <= rgs_rcom_q;
                default:                rd_data <= rhm_pkg::RST_ZERO;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs to analog
    // ----------------------------------------------------------------
    assign mix_rgs_rhp   = rgs_rhp_q;   // [RQ1]
    assign mix_rdac_rhp  = rdac_rhp_q;  // [RQ2]
    assign mix_lgs_rcom  = lgs_rcom_q;  // [RQ3]
    assign mix_ldac_rcom = ldac_rcom_q; // [RQ4]
    assign mix_rgs_rcom  = rgs_rcom_q;  // [RQ5]
    assign drv.level  = ctrl_q[rhm_pkg::LVL_HI:rhm_pkg::LVL_LO]; // [RQ6]
    assign drv.unmute = ctrl_q[rhm_pkg::MUTE_BIT]; // [RQ8]
    assign drv.pd_hiz = ctrl_q[rhm_pkg::PDHZ_BIT]; // [RQ9]
    assign drv.power  = ctrl_q[rhm_pkg::PWR_BIT];  // [RQ11]

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_mix_wr; // write lands next cycle
        @(posedge mclk) disable iff (!nrst)
        wr_hit(wr_req, rhm_pkg::IDX_RGS_RHP)
        |=> mix_rgs_rhp == $past(wr_req.data);
    endproperty
    a_mix_wr: assert property (p_mix_wr) // [RQ1]
        else $error("right gain mix write lost");

    property p_dac_wr;
        @(posedge mclk) disable iff (!nrst)
        wr_hit(wr_req, rhm_pkg::IDX_RDAC_RHP)
        |=> mix_rdac_rhp == $past(wr_req.data);
    endproperty
    a_dac_wr: assert property (p_dac_wr) // [RQ2]
        else $error("right dac mix write lost");

    property p_lgs_wr;
        @(posedge mclk) disable iff (!nrst)
        wr_hit(wr_req, rhm_pkg::IDX_LGS_RCOM)
        |=> mix_lgs_rcom == $past(wr_req.data);
    endproperty
    a_lgs_wr: assert property (p_lgs_wr) // [RQ3]
        else $error("left gain common write lost");

    property p_ldac_wr;
        @(posedge mclk) disable iff (!nrst)
        wr_hit(wr_req, rhm_pkg::IDX_LDAC_RCOM)
        |=> mix_ldac_rcom == $past(wr_req.data);
    endproperty
    a_ldac_wr: assert property (p_ldac_wr) // [RQ4]
        else $error("left dac common write lost");

    property p_rgs_wr; // common path write lands next cycle
        @(posedge mclk) disable iff (!nrst)
        wr_hit(wr_req, rhm_pkg::IDX_RGS_RCOM)
        |=> mix_rgs_rcom == $past(wr_req.data);
    endproperty
    a_rgs_wr: assert property (p_rgs_wr) // [RQ5]
        else $error("right gain common write lost");

    property p_rgs_hold; // untouched register keeps value
        @(posedge mclk) disable iff (!nrst)
        !wr_hit(wr_req, rhm_pkg::IDX_RGS_RCOM) |=> $stable(mix_rgs_rcom);
    endproperty
    a_rgs_hold: assert property (p_rgs_hold) // [RQ5]
        else $error("right gain common changed unwritten");

    property p_ctrl_wr; // control fields follow write
        @(posedge mclk) disable iff (!nrst)
        wr_hit(wr_req, rhm_pkg::IDX_RHP_CTRL)
        |=> drv == {$past(wr_req.data[rhm_pkg::LVL_HI:rhm_pkg::PDHZ_BIT]),
                    $past(wr_req.data[rhm_pkg::PWR_BIT])};
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) // [RQ6]
        else $error("driver control write lost");

    sequence s_gain_wr;
        gain_wr;
    endsequence
    sequence s_pend_rd;
        ##1 (rd_idx == rhm_pkg::IDX_RHP_CTRL && hit_page && !gain_done)
        ##1 rd_data[rhm_pkg::PEND_BIT];
    endsequence
    property p_pend; // write then read shows pending
        @(posedge mclk) disable iff (!nrst)
        s_gain_wr |-> (s_pend_rd or
            ##1 !(rd_idx == rhm_pkg::IDX_RHP_CTRL && hit_page && !gain_done));
    endproperty
    a_pend: assert property (p_pend) // [RQ10]
        else $error("pending flag not shown after gain write");

    property p_done; // completion with no write clears
        @(posedge mclk) disable iff (!nrst)
        (gain_done && !gain_wr) |=> !pend_q;
    endproperty
    a_done: assert property (p_done) // [RQ10]
        else $error("pending flag stuck after completion");

    property p_page; // other pages read zero
        @(posedge mclk) disable iff (!nrst)
        !hit_page |=> rd_data == rhm_pkg::RST_ZERO;
    endproperty
    a_page: assert property (p_page) // [RQ13]
        else $error("non-zero read off page zero");

endmodule

/* rhm_regs_tb_top.sv */
// self-checking bench for the right headphone mix register bank
`timescale 1ns/1ps

module rhm_regs_tb_top;

    // ----------------------------------------------------------------
    // design connections and bench state
    // ----------------------------------------------------------------
    logic              mclk;          // 100 MHz bench clock
    logic              nrst;          // async reset, low
    rhm_pkg::rhm_wr_s  wr_req;        // write request bundle
    logic [7:0]        rd_page;       // read page
    logic [7:0]        rd_idx;        // read index
    logic [7:0]        rd_data;       // registered read data
    logic              gain_done;     // analog ramp finished
    rhm_pkg::rhm_mix_s mix_rgs_rhp;   // right gain -> hp
    rhm_pkg::rhm_mix_s mix_rdac_rhp;  // right dac -> hp
    rhm_pkg::rhm_mix_s mix_lgs_rcom;  // left gain -> com
    rhm_pkg::rhm_mix_s mix_ldac_rcom; // left dac -> com
    rhm_pkg::rhm_mix_s mix_rgs_rcom;  // right gain -> com
    rhm_pkg::rhm_drv_s drv;           // driver controls
    logic [7:0]        mdl [0:8];     // expected contents, 0x3E upward
    logic              pend;          // expected pending flag
    int                failures;      // mismatch count
    int                check_count;   // comparison count
    int                cycles;        // hang guard

    rhm_regs dut (.mclk(mclk), .nrst(nrst), .wr_req(wr_req),
        .rd_page(rd_page), .rd_idx(rd_idx), .rd_data(rd_data),
        .gain_done(gain_done), .mix_rgs_rhp(mix_rgs_rhp),
        .mix_rdac_rhp(mix_rdac_rhp), .mix_lgs_rcom(mix_lgs_rcom),
        .mix_ldac_rcom(mix_ldac_rcom), .mix_rgs_rcom(mix_rgs_rcom),
        .drv(drv));

    // ----------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ----------------------------------------------------------------
    // free-running clock, 10 ns period
    always #5 mclk = ~mclk;

    // the whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            summarize();
        end
    end

    // one comparison, counted and reported
    task automatic check(input logic [7:0] seen, input logic [7:0] want,
                         input string what);
        check_count++;
        if (seen !== want)
        begin
            failures++;
            $display("mismatch at %0t: %s seen %h want %h", $time, what,
                     seen, want);
        end
    endtask

    // closing report, the only exit
    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // expected read value; off-page and unmapped places read zero
    function automatic logic [7:0] exp_rd(input logic [7:0] pg,
                                          input logic [7:0] ix);
        if (pg != 8'h00 || ix < 8'h3E || ix > 8'h46)
            return 8'h00;
        if (ix == 8'h41)
            return mdl[3] | {6'h00, pend, 1'b0};
        return mdl[ix - 8'h3E];
    endfunction

    // hold reset eight cycles and reload the expected contents
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        foreach (mdl[k]) mdl[k] = 8'h00;
        mdl[3] = 8'h04; // hi-z when down, all else clear
        pend = 1'b1;
    endtask

    // one write, optionally with a gain-applied pulse in the same cycle
    task automatic wr(input logic [7:0] pg, input logic [7:0] ix,
                      input logic [7:0] dt, input logic done);
        int k;
        k = int'(ix) - 'h3E;
        @(posedge mclk);
        wr_req <= '{wr: 1'b1, page: pg, idx: ix, data: dt};
        gain_done <= done;
        @(posedge mclk);
        wr_req.wr <= 1'b0;
        gain_done <= 1'b0;
        // a write to a mix or control place beats a same-cycle done
        if (pg == 8'h00 && k >= 0 && k <= 8)
        begin
            mdl[k] = (k == 3) ? (dt & 8'hFD) : dt;
            if (k != 0 && k != 4 && k != 7)
                pend = 1'b1;
            else if (done)
                pend = 1'b0;
        end
        else if (done)
            pend = 1'b0;
    endtask

    // read one place: address at one edge, data after the next
    task automatic rd(input logic [7:0] pg, input logic [7:0] ix);
        @(posedge mclk);
        rd_page <= pg;
        rd_idx <= ix;
        @(posedge mclk);
        #1;
        check(rd_data, exp_rd(pg, ix), "read back");
    endtask

    // all register-driven outputs against the expected contents
    task automatic check_outs;
        #1;
        check(mix_rgs_rhp, mdl[1], "right gain to hp");
        check(mix_rdac_rhp, mdl[2], "right dac to hp");
        check(mix_lgs_rcom, mdl[5], "left gain to com");
        check(mix_ldac_rcom, mdl[6], "left dac to com");
        check(mix_rgs_rcom, mdl[8], "right gain to com");
        check({1'b0, drv}, {1'b0, mdl[3][7:2], mdl[3][0]}, "driver");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] d;
        logic [7:0] ix;
        mclk = 1'b0;
        nrst = 1'b0;
        wr_req = '0;
        rd_page = 8'h00;
        rd_idx = 8'h00;
        gain_done = 1'b0;
        void'($urandom(49011));
        // reset contents, including the unmapped neighbours
        do_reset();
        check_outs();
        for (int i = 'h3D; i <= 'h47; i++) rd(8'h00, 8'(i));
        // every legal level code with random mute, drive, power bits
        for (int lv = 0; lv <= 9; lv++)
        begin
            wr(8'h00, 8'h41, {4'(lv), 4'($urandom)}, 1'b0);
            check_outs();
        end
        // pending is read-only, set by writes, cleared by done
        wr(8'h00, 8'h41, 8'h3B, 1'b1);
        rd(8'h00, 8'h41);
        @(posedge mclk);
        gain_done <= 1'b1;
        @(posedge mclk);
        gain_done <= 1'b0;
        pend = 1'b0;
        rd(8'h00, 8'h41);
        wr(8'h00, 8'h3E, 8'hA5, 1'b0);
        rd(8'h00, 8'h41);
        wr(8'h00, 8'h40, 8'h80, 1'b0);
        rd(8'h00, 8'h41);
        // reserved places keep what is written; other pages ignored
        wr(8'h00, 8'h42, 8'h5A, 1'b0);
        wr(8'h00, 8'h45, 8'hFF, 1'b0);
        wr(8'h01, 8'h3F, 8'hFF, 1'b0);
        wr(8'h00, 8'h47, 8'hFF, 1'b0);
        check_outs();
        foreach (mdl[k]) rd(8'h00, 8'(k + 'h3E));
        rd(8'h01, 8'h3F);
        // random traffic over the mix and control places
        repeat (60)
        begin
            ix = 8'($urandom_range('h46, 'h3F));
            d = 8'($urandom);
            if (ix == 8'h41)
                d[7:4] = 4'($urandom_range(9));
            if (ix != 8'h42 && ix != 8'h45)
                wr(8'h00, ix, d, 1'($urandom));
            check_outs();
            rd(8'($urandom_range(1) * $urandom_range(3)),
               8'($urandom_range('h48, 'h3C)));
        end
        // second reset in mid-run restores every place
        wr(8'h00, 8'h3F, 8'hC3, 1'b0);
        do_reset();
        check_outs();
        foreach (mdl[k]) rd(8'h00, 8'(k + 'h3E));
        summarize();
    end

endmodule
